// File: pkg/eae_pkg.sv
// =====================================================================
// energy accumulation engine constants
package eae_pkg;
	// =================================================================
	// widths
	localparam int ACC_W = 42;
	localparam int USER_W = 45;
	localparam int HIGH_W = 32;
	localparam int LOW_W = 13;
	localparam int INTERVAL_W = 13;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	// =================================================================
	// register offsets
	localparam logic [7:0] CFG_OFS = 8'h00;
	localparam logic [7:0] INTERVAL_OFS = 8'h04;
	localparam logic [7:0] STATUS_OFS = 8'h08;
	localparam logic [7:0] MASK_OFS = 8'h0c;
	localparam logic [7:0] ENERGY_BASE_OFS = 8'h10;
	localparam logic [7:0] ENERGY_STRIDE = 8'h08;
	localparam logic [7:0] ENERGY_LOW_OFS = 8'h04;
	// =================================================================
	// accumulation_config fields
	localparam int CFG_ENABLE_BIT = 0;
	localparam int CFG_UNIT_BIT = 1;
	localparam int CFG_LOAD_BIT = 2;
	localparam int CFG_COR_BIT = 3;
	localparam int CFG_ZXSEL_LSB = 4;
	localparam int ZXSEL_W = 2;
	// =================================================================
	// status and mask fields
	localparam int STATUS_EGY_BIT = 0;
	// =================================================================
	// reset values
	localparam logic [DATA_W-1:0] CFG_RESET = 32'h0000_0000;
	localparam logic [INTERVAL_W-1:0] INTERVAL_RESET = 13'h0000;
	localparam logic STATUS_RESET = 1'h0;
	localparam logic MASK_RESET = 1'h0;
	// =================================================================
	// interval unit
	typedef enum logic {
		EAE_UNIT_SAMPLE,
		EAE_UNIT_HALF_CYCLE
	} eae_unit_t;
endpackage

// File: core/eae_channel.sv
`timescale 1ns/1ns
module eae_channel #(
	parameter int SAMPLE_W = 32
) (
	input wire logic core_clk, // core clock
	input wire logic nrst, // async reset, active low
	input wire logic sample_valid, // accepted power sample this cycle
	input wire logic signed [SAMPLE_W-1:0] power_sample, // power sample
	input wire logic no_load, // add zero instead of the sample
	input wire logic xfer, // transfer tick, one cycle before energy_ready_tick
	input wire logic load_mode, // overwrite instead of add
	input wire logic clear_high, // clear-on-read of the high word
	output logic signed [eae_pkg::ACC_W-1:0] internal_acc, // internal sum
	output logic [eae_pkg::HIGH_W-1:0] energy_high, // user high word
	output logic [eae_pkg::LOW_W-1:0] energy_low // user low part
);
	logic signed [eae_pkg::ACC_W-1:0] acc_q;
	logic signed [eae_pkg::ACC_W-1:0] add_val;
	logic signed [eae_pkg::ACC_W-1:0] acc_d;
	logic signed [eae_pkg::USER_W-1:0] user_q;
	logic signed [eae_pkg::USER_W-1:0] user_base;
	logic signed [eae_pkg::USER_W-1:0] sum_ext;
	logic signed [eae_pkg::USER_W-1:0] user_d;

	// =================================================================
	// internal accumulator
	always_comb
	begin
		add_val = '0;
		if (sample_valid && !no_load)
			add_val = eae_pkg::ACC_W'(power_sample);
		acc_d = acc_q + add_val;
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			acc_q <= '0;
		else if (xfer)
			acc_q <= '0;
		else
			acc_q <= acc_d;
	end

	// =================================================================
	// user energy register
	always_comb
	begin
		sum_ext = eae_pkg::USER_W'(acc_d);
		user_base = user_q;
		if (clear_high)
			user_base = {{eae_pkg::HIGH_W{1'b0}}, user_q[eae_pkg::LOW_W-1:0]};
		user_d = user_base;
		if (xfer && load_mode)
			user_d = sum_ext;
		else if (xfer)
			user_d = user_base + sum_ext;
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			user_q <= '0;
		else
			user_q <= user_d;
	end

	assign energy_high = user_q[eae_pkg::USER_W-1:eae_pkg::LOW_W];
	assign energy_low = user_q[eae_pkg::LOW_W-1:0];
	assign internal_acc = acc_q;
endmodule

// File: core/eae_top.sv
`timescale 1ns/1ns
module eae_top #(
	parameter int NUM_CH = 3,
	parameter int SAMPLE_W = 32
) (
	input wire logic core_clk, // 125 MHz core clock
	input wire logic nrst, // async reset, active low
	input wire logic [eae_pkg::ADDR_W-1:0] reg_addr, // register byte address
	input wire logic [eae_pkg::DATA_W-1:0] reg_wdata, // register write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [eae_pkg::DATA_W-1:0] reg_rdata, // read data, cycle after strobe
	input wire logic sample_tick, // 8 ksps sample strobe
	input wire logic [NUM_CH*SAMPLE_W-1:0] power_samples, // signed samples
	input wire logic [NUM_CH-1:0] no_load, // per-channel no-load flags
	input wire logic [(1<<eae_pkg::ZXSEL_W)-1:0] zero_cross, // zero-cross pulses
	output logic energy_ready_tick, // one-cycle pulse after each transfer
	output logic irq // level interrupt
);
	logic enable_q;
	eae_pkg::eae_unit_t unit_q;
	logic load_q;
	logic cor_q;
	logic [eae_pkg::ZXSEL_W-1:0] zxsel_q;
	logic [eae_pkg::INTERVAL_W-1:0] interval_q;
	logic [eae_pkg::INTERVAL_W-1:0] cnt_q;
	logic status_q;
	logic mask_q;
	logic tick_q;
	logic [eae_pkg::DATA_W-1:0] rdata_q;
	logic [eae_pkg::DATA_W-1:0] rdata_d;
	logic unit_event;
	logic tick;
	logic cfg_wr;
	logic interval_wr;
	logic [NUM_CH-1:0] clear_high;
	logic [eae_pkg::HIGH_W-1:0] high_w [NUM_CH];
	logic [eae_pkg::LOW_W-1:0] low_w [NUM_CH];
	logic signed [eae_pkg::ACC_W-1:0] acc_w [NUM_CH];

	assign cfg_wr = reg_wr && (reg_addr == eae_pkg::CFG_OFS);
	assign interval_wr = reg_wr && (reg_addr == eae_pkg::INTERVAL_OFS);

	// =================================================================
	// configuration registers
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			enable_q <= eae_pkg::CFG_RESET[eae_pkg::CFG_ENABLE_BIT];
			unit_q <= eae_pkg::EAE_UNIT_SAMPLE;
			load_q <= eae_pkg::CFG_RESET[eae_pkg::CFG_LOAD_BIT];
			cor_q <= eae_pkg::CFG_RESET[eae_pkg::CFG_COR_BIT];
			zxsel_q <= '0;
		end
		else if (cfg_wr)
		begin
			enable_q <= reg_wdata[eae_pkg::CFG_ENABLE_BIT];
			unit_q <= eae_pkg::eae_unit_t'(reg_wdata[eae_pkg::CFG_UNIT_BIT]);
			load_q <= reg_wdata[eae_pkg::CFG_LOAD_BIT];
			cor_q <= reg_wdata[eae_pkg::CFG_COR_BIT];
			zxsel_q <= reg_wdata[eae_pkg::CFG_ZXSEL_LSB +: eae_pkg::ZXSEL_W];
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			interval_q <= eae_pkg::INTERVAL_RESET;
		else if (interval_wr)
			interval_q <= reg_wdata[eae_pkg::INTERVAL_W-1:0];
	end

	// =================================================================
	// interval counter
	always_comb
	begin
		if (unit_q == eae_pkg::EAE_UNIT_HALF_CYCLE)
			unit_event = zero_cross[zxsel_q];
		else
			unit_event = sample_tick;
		// compare with >= so a lowered count never strands the counter
		tick = enable_q && unit_event && (cnt_q >= interval_q);
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			cnt_q <= '0;
		else if (!enable_q)
			cnt_q <= '0;
		else if (tick)
			cnt_q <= '0;
		else if (unit_event)
			cnt_q <= cnt_q + 1'b1;
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			tick_q <= 1'b0;
		else
			tick_q <= tick;
	end

	assign energy_ready_tick = tick_q;

	// =================================================================
	// energy channels
	for (genvar i = 0; i < NUM_CH; i++)
	begin : g_ch
		localparam logic [eae_pkg::ADDR_W-1:0] HI_A =
			eae_pkg::ADDR_W'(eae_pkg::ENERGY_BASE_OFS + eae_pkg::ENERGY_STRIDE * i);
		assign clear_high[i] = reg_rd && cor_q && (reg_addr == HI_A);
		eae_channel #(
			.SAMPLE_W(SAMPLE_W)
		) u_ch (
			.core_clk(core_clk),
			.nrst(nrst),
			.sample_valid(sample_tick && enable_q),
			.power_sample(power_samples[i*SAMPLE_W +: SAMPLE_W]),
			.no_load(no_load[i]),
			.xfer(tick),
			.load_mode(load_q),
			.clear_high(clear_high[i]),
			.internal_acc(acc_w[i]),
			.energy_high(high_w[i]),
			.energy_low(low_w[i])
		);
	end

	// =================================================================
	// interrupt
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			status_q <= eae_pkg::STATUS_RESET;
		else if (tick)
			status_q <= 1'b1;
		else if (reg_wr && reg_addr == eae_pkg::STATUS_OFS
			&& reg_wdata[eae_pkg::STATUS_EGY_BIT])
			status_q <= 1'b0;
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			mask_q <= eae_pkg::MASK_RESET;
		else if (reg_wr && reg_addr == eae_pkg::MASK_OFS)
			mask_q <= reg_wdata[eae_pkg::STATUS_EGY_BIT];
	end

	assign irq = status_q && mask_q;

	// =================================================================
	// read path
	always_comb
	begin
		rdata_d = '0;
		if (reg_addr == eae_pkg::CFG_OFS)
		begin
			rdata_d[eae_pkg::CFG_ENABLE_BIT] = enable_q;
			rdata_d[eae_pkg::CFG_UNIT_BIT] = unit_q;
			rdata_d[eae_pkg::CFG_LOAD_BIT] = load_q;
			rdata_d[eae_pkg::CFG_COR_BIT] = cor_q;
			rdata_d[eae_pkg::CFG_ZXSEL_LSB +: eae_pkg::ZXSEL_W] = zxsel_q;
		end
		else if (reg_addr == eae_pkg::INTERVAL_OFS)
			rdata_d[eae_pkg::INTERVAL_W-1:0] = interval_q;
		else if (reg_addr == eae_pkg::STATUS_OFS)
			rdata_d[eae_pkg::STATUS_EGY_BIT] = status_q;
		else if (reg_addr == eae_pkg::MASK_OFS)
			rdata_d[eae_pkg::STATUS_EGY_BIT] = mask_q;
		else
		begin
			for (int c = 0; c < NUM_CH; c++)
			begin
				if (reg_addr == eae_pkg::ADDR_W'(eae_pkg::ENERGY_BASE_OFS
					+ eae_pkg::ENERGY_STRIDE * c))
					rdata_d = high_w[c];
				else if (reg_addr == eae_pkg::ADDR_W'(eae_pkg::ENERGY_BASE_OFS
					+ eae_pkg::ENERGY_STRIDE * c + eae_pkg::ENERGY_LOW_OFS))
					rdata_d = {{(eae_pkg::DATA_W-eae_pkg::LOW_W){1'b0}}, low_w[c]};
			end
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			rdata_q <= '0;
		else if (reg_rd)
			rdata_q <= rdata_d;
		else
			rdata_q <= '0;
	end

	assign reg_rdata = rdata_q;

	// =================================================================
	// checks
	logic [eae_pkg::INTERVAL_W:0] ha_units_q;
	logic ha_dirty_q;
	logic signed [eae_pkg::ACC_W-1:0] ha_add0;
	logic signed [eae_pkg::USER_W-1:0] ha_sum0;
	logic signed [eae_pkg::USER_W-1:0] ha_user0;
	logic ha_irq_wr;

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ha_units_q <= '0;
			ha_dirty_q <= 1'b1;
		end
		else if (tick || !enable_q)
		begin
			ha_units_q <= '0;
			ha_dirty_q <= cfg_wr || interval_wr || !enable_q;
		end
		else
		begin
			if (unit_event)
				ha_units_q <= ha_units_q + 1'b1;
			if (cfg_wr || interval_wr)
				ha_dirty_q <= 1'b1;
		end
	end

	assign ha_add0 = (sample_tick && enable_q && !no_load[0])
		? eae_pkg::ACC_W'($signed(power_samples[SAMPLE_W-1:0])) : '0;
	assign ha_sum0 = eae_pkg::USER_W'(eae_pkg::ACC_W'(acc_w[0] + ha_add0));
	assign ha_user0 = {high_w[0], low_w[0]};
	assign ha_irq_wr = reg_wr
		&& (reg_addr == eae_pkg::MASK_OFS || reg_addr == eae_pkg::STATUS_OFS);

	tick_sample_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(tick && !ha_dirty_q && unit_q == eae_pkg::EAE_UNIT_SAMPLE)
		|-> (ha_units_q == {1'b0, interval_q}))
		else $error("sample interval length wrong");

	tick_halfcyc_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(tick && !ha_dirty_q && unit_q == eae_pkg::EAE_UNIT_HALF_CYCLE)
		|-> (ha_units_q == {1'b0, interval_q}) && zero_cross[zxsel_q])
		else $error("half-cycle interval length wrong");

	interval_write_a: assert property (@(posedge core_clk) disable iff (!nrst)
		interval_wr |=> (interval_q == $past(reg_wdata[eae_pkg::INTERVAL_W-1:0])))
		else $error("interval count not stored");

	load_xfer_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(tick && load_q) |=> (ha_user0 == $past(ha_sum0)))
		else $error("overwrite transfer wrong");

	add_xfer_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(tick && !load_q && !clear_high[0])
		|=> (ha_user0 == eae_pkg::USER_W'($past(ha_user0) + $past(ha_sum0))))
		else $error("add transfer wrong");

	acc_restart_a: assert property (@(posedge core_clk) disable iff (!nrst)
		tick |=> (acc_w[0] == '0))
		else $error("internal sum not cleared");

	acc_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(!enable_q ##1 !enable_q) |-> $stable(acc_w[0]) && !tick)
		else $error("accumulation while disabled");

	noload_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(no_load[NUM_CH-1] && !tick) |=> (acc_w[NUM_CH-1] == $past(acc_w[NUM_CH-1])))
		else $error("no-load channel accumulated");

	read_clear_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(clear_high[0] && !tick) |=> (high_w[0] == '0) && $stable(low_w[0]))
		else $error("clear-on-read wrong");

	// status flag and interrupt
	irq_level_a: assert property (@(posedge core_clk) disable iff (!nrst)
		(tick && mask_q && !ha_irq_wr) ##1 !ha_irq_wr |-> irq ##1 irq)
		else $error("interrupt not raised");
endmodule

// File: test/eae_host_model.sv
`timescale 1ns/1ns
// =====================================================================
// host register master
module eae_host_model (
	input wire logic core_clk, // core clock
	input wire logic [31:0] reg_rdata, // read data
	output logic [7:0] reg_addr, // byte address
	output logic [31:0] reg_wdata, // write data
	output logic reg_wr, // write strobe
	output logic reg_rd // read strobe
);
	initial
	begin
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// released lines show inverted values
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(posedge core_clk);
		d = reg_rdata;
	endtask
	task automatic cor_setup();
		wr(8'h04, 32'h0000_0001);
		wr(8'h00, 32'h0000_0009);
	endtask
	task automatic line_setup(input logic [1:0] zx, input logic [12:0] n);
		wr(8'h04, {19'h0, (n < 13'd1329) ? n : 13'd1328});
		wr(8'h00, {26'h0, zx, 4'h7});
	endtask
	task automatic count_setup(input logic [12:0] n);
		wr(8'h04, {19'h0, n});
		wr(8'h00, 32'h0000_0005);
	endtask
endmodule

// File: test/tb.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb;
	logic core_clk, nrst, reg_wr, reg_rd, sample_tick, energy_ready_tick, irq;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [95:0] power_samples;
	logic [2:0] no_load;
	logic [3:0] zero_cross;
	int err_count = 0;
	int comparisons = 0;
	int cycles = 0;
	eae_top i_eae_top (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.sample_tick(sample_tick), .power_samples(power_samples), .no_load(no_load),
		.zero_cross(zero_cross), .energy_ready_tick(energy_ready_tick), .irq(irq));
	eae_host_model i_eae_host_model (.core_clk(core_clk), .reg_rdata(reg_rdata),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// =================================================================
	// closing and hang guard
	task automatic complete_run();
		$display("mismatches %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			err_count++;
			complete_run();
		end
	end
	// =================================================================
	// helpers
	task automatic chk_reg(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		i_eae_host_model.rd(a, d);
		`CHK(nm, e, d)
	endtask
	task automatic step(input logic st, input logic [3:0] zx, input logic [31:0] s0, s1,
		output logic rdy);
		@(posedge core_clk);
		sample_tick <= st;
		zero_cross <= zx;
		power_samples <= {32'h0000_03e8, s1, s0};
		@(posedge core_clk);
		sample_tick <= 1'b0;
		zero_cross <= 4'h0;
		power_samples <= ~{32'h0000_03e8, s1, s0};
		#1 rdy = energy_ready_tick;
	endtask
	task automatic run(input int n, input logic [31:0] s0, s1);
		logic rdy;
		for (int i = 0; i < n; i++)
		begin
			step(1'b1, 4'h0, s0, s1, rdy);
			if (i < n - 1)
				`CHK("early tick", 1'b0, rdy)
		end
		`CHK("ready tick", 1'b1, rdy)
	endtask
	// =================================================================
	// scenarios
	task automatic t_reset();
		chk_reg("cfg", 8'h00, 32'h0000_0000);
		chk_reg("status", 8'h08, 32'h0000_0000);
		chk_reg("high0", 8'h10, 32'h0000_0000);
		chk_reg("unmapped", 8'hfc, 32'h0000_0000);
		i_eae_host_model.wr(8'h04, 32'hffff_ffff);
		chk_reg("interval", 8'h04, 32'h0000_1fff);
	endtask
	task automatic t_add();
		i_eae_host_model.wr(8'h0c, 32'h0000_0001);
		i_eae_host_model.wr(8'h04, 32'h0000_0002);
		i_eae_host_model.wr(8'h00, 32'h0000_0001);
		run(3, 32'hffff_fffb, 32'h0000_1000);
		chk_reg("status", 8'h08, 32'h0000_0001);
		`CHK("irq set", 1'b1, irq)
		chk_reg("high0", 8'h10, 32'hffff_ffff);
		chk_reg("low0", 8'h14, 32'h0000_1ff1);
		chk_reg("high1", 8'h18, 32'h0000_0001);
		chk_reg("high2", 8'h20, 32'h0000_0000);
		i_eae_host_model.wr(8'h08, 32'h0000_0001);
		repeat (2) @(posedge core_clk);
		#1 `CHK("irq clear", 1'b0, irq)
		run(3, 32'hffff_fffb, 32'h0000_1000);
		chk_reg("low0", 8'h14, 32'h0000_1fe2);
		chk_reg("high1", 8'h18, 32'h0000_0003);
		chk_reg("low1", 8'h1c, 32'h0000_0000);
		i_eae_host_model.wr(8'h0c, 32'h0000_0000);
		repeat (2) @(posedge core_clk);
		#1 `CHK("irq masked", 1'b0, irq)
		i_eae_host_model.wr(8'h08, 32'h0000_0001);
	endtask
	task automatic t_disable();
		logic rdy;
		i_eae_host_model.wr(8'h00, 32'h0000_0000);
		for (int i = 0; i < 3; i++)
		begin
			step(1'b1, 4'h0, 32'h0000_0064, 32'h0000_0000, rdy);
			`CHK("idle tick", 1'b0, rdy)
		end
		i_eae_host_model.wr(8'h00, 32'h0000_0001);
		run(3, 32'h0000_0001, 32'h0000_0000);
		chk_reg("low0", 8'h14, 32'h0000_1fe5);
		chk_reg("high0", 8'h10, 32'hffff_ffff);
	endtask
	task automatic t_load();
		i_eae_host_model.count_setup(13'h0000);
		run(1, 32'h0000_0007, 32'h0000_0000);
		chk_reg("low0", 8'h14, 32'h0000_0007);
		run(1, 32'h0000_0003, 32'h0000_0000);
		chk_reg("high0", 8'h10, 32'h0000_0000);
		chk_reg("low0", 8'h14, 32'h0000_0003);
	endtask
	task automatic t_cor();
		i_eae_host_model.cor_setup();
		run(2, 32'h0000_1000, 32'h0000_3001);
		chk_reg("high0", 8'h10, 32'h0000_0001);
		chk_reg("high0 again", 8'h10, 32'h0000_0000);
		chk_reg("low0", 8'h14, 32'h0000_0003);
		chk_reg("high1", 8'h18, 32'h0000_0003);
		chk_reg("high1 again", 8'h18, 32'h0000_0000);
		chk_reg("low1", 8'h1c, 32'h0000_0002);
	endtask
	task automatic t_half();
		logic rdy;
		logic [3:0] zx [6] = '{4'h0, 4'h2, 4'h4, 4'h0, 4'h2, 4'h4};
		i_eae_host_model.line_setup(2'h2, 13'h0001);
		for (int i = 0; i < 12; i++)
		begin
			step(zx[i % 6] == 4'h0, zx[i % 6], 32'h0000_000a, 32'h0000_0000, rdy);
			`CHK("half tick", i % 6 == 5, rdy)
		end
		chk_reg("low0", 8'h14, 32'h0000_0014);
	endtask
	initial
	begin
		nrst = 1'b0;
		sample_tick = 1'b0;
		zero_cross = 4'h0;
		power_samples = '0;
		no_load = 3'b100;
		repeat (10) @(posedge core_clk);
		nrst <= 1'b1;
		t_reset();
		t_add();
		t_disable();
		t_load();
		t_cor();
		t_half();
		complete_run();
	end
endmodule
